// ### rtl/pin_mux_pkg.sv
/*
 * Constants and carrier types for the pin function multiplexer that
 * serves port A bits two to six and port B bit one.
 * Assumes config nibbles, remap and enable bits arrive as plain levels.
 */
// Operation
// - A2 drives timer two channel four output
// - Timer two channel four input from A2
// - A2 open-drain carries controller two TWI clock
// - A2 drives controller two SPI master clock
// - SPI slave clock input taken from A2
// - SPI slave select input taken from A3
// - A3 drives synchronous CPU trace clock
// - A3 timer two channel two in/out
// - A4 analog nibble selects ADC input four
// - A4 drives packet trace frame signal
// - A4 drives CPU trace data bit two
// - A5 analog nibble selects ADC input five
// - A5 drives packet trace data signal
// - Boot strap on A5 sampled around reset
// - A5 drives CPU trace data bit three
// - A6 drives timer one channel three output
// - Timer one channel three input from A6
// - B1 drives controller one SPI slave out
// - B1 drives controller one SPI master out
// - B1 open-drain carries controller one TWI data
// - B1 drives controller one UART transmit
// - B1 drives remapped timer two channel one
package pin_mux_pkg;
    // ------------------------------------------------------------
    // Config nibble codes
    // ------------------------------------------------------------
    localparam logic [3:0] CFG_ANALOG  = 4'h0; // Analog: released, digital input cut on A4, A5 only
    localparam logic [3:0] CFG_GPIO_PP = 4'h1; // GPIO push-pull out
    localparam logic [3:0] CFG_GPIO_OD = 4'h5; // GPIO open-drain out
    localparam logic [3:0] CFG_ALT_PP  = 4'h9; // Alternate push-pull
    localparam logic [3:0] CFG_ALT_OD  = 4'hd; // Alternate open-drain
    // ------------------------------------------------------------
    // Nibble positions inside the config words
    // ------------------------------------------------------------
    localparam int NIB_A2 = 2; // Low config [11:8]
    localparam int NIB_A3 = 3; // Low config [15:12]
    localparam int NIB_A4 = 0; // High config [3:0]
    localparam int NIB_A5 = 1; // High config [7:4]
    localparam int NIB_A6 = 2; // High config [11:8]
    localparam int NIB_B1 = 1; // Port B low config [7:4]
    // ------------------------------------------------------------
    // Remap, role and channel bit positions
    // ------------------------------------------------------------
    localparam int REMAP_CH1 = 4;
    localparam int REMAP_CH2 = 5;
    localparam int REMAP_CH4 = 7;
    localparam int ROLE_MST  = 4; // Set: master, clear: slave
    localparam int CH1 = 0;
    localparam int CH2 = 1;
    localparam int CH3 = 2;
    localparam int CH4 = 3;
    // ------------------------------------------------------------
    // Serial controller modes and pin indices
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_OFF  = 2'b00,
        MODE_UART = 2'b01,
        MODE_SPI  = 2'b10,
        MODE_TWI  = 2'b11
    } sc_mode_t;
    localparam int P_A2 = 0;
    localparam int P_A3 = 1;
    localparam int P_A4 = 2;
    localparam int P_A5 = 3;
    localparam int P_A6 = 4;
    localparam int P_B1 = 5;
    localparam int NPINS = 6;
    localparam int SYNC_DEPTH = 3;
    // Drive of one pin: value and active-low output enable
    typedef struct packed {
        logic val;
        logic oe_n;
    } pin_drive_t;
endpackage : pin_mux_pkg

// ### rtl/pin_function_mux.sv
/*
 * Pin function multiplexer for port A bits two to six and port B bit
 * one, with three-stage input filtering and the boot strap latch.
 * Assumes peripherals and config sit on i_core_clk; pins are async.
 */
`timescale 1ns/100ps
module pin_function_mux
    import pin_mux_pkg::*;
#(
    parameter int SYNC_STAGES = SYNC_DEPTH
) (
    // Clock and reset
    input  wire logic        i_core_clk,
    input  wire logic        i_sys_rst,
    // Pad side
    input  wire logic [5:0]  i_pin_in,
    output logic [5:0]       o_pin_out,
    output logic [5:0]       o_pin_oe_n,
    // Configuration
    input  wire logic [15:0] i_port_a_low_config,
    input  wire logic [15:0] i_port_a_high_config,
    input  wire logic [15:0] i_port_b_low_config,
    input  wire logic [7:0]  i_timer_two_remap_bits,
    input  wire logic [3:0]  i_timer_two_output_enables,
    input  wire logic [3:0]  i_timer_one_output_enables,
    input  wire sc_mode_t    i_ctrl_two_mode_select,
    input  wire logic [7:0]  i_ctrl_two_spi_role,
    input  wire sc_mode_t    i_ctrl_one_mode_select,
    input  wire logic [7:0]  i_ctrl_one_spi_role,
    input  wire logic        i_trace_enable,
    input  wire logic        i_trace_four_wire,
    input  wire logic        i_packet_trace_enable,
    // Peripheral outputs toward pins
    input  wire logic [5:0]  i_gpio_out,
    input  wire logic        i_timer_two_channel_four,
    input  wire logic        i_timer_two_channel_two,
    input  wire logic        i_timer_two_channel_one,
    input  wire logic        i_timer_one_channel_three,
    input  wire logic        i_ctrl_two_twi_clock,
    input  wire logic        i_ctrl_two_spi_clock,
    input  wire logic        i_cpu_trace_clock,
    input  wire logic        i_cpu_trace_bit_two,
    input  wire logic        i_cpu_trace_bit_three,
    input  wire logic        i_packet_trace_frame,
    input  wire logic        i_packet_trace_serial,
    input  wire logic        i_ctrl_one_slave_out,
    input  wire logic        i_ctrl_one_master_out,
    input  wire logic        i_ctrl_one_twi_data,
    input  wire logic        i_ctrl_one_uart_tx,
    // Filtered inputs toward peripherals
    output logic [5:0]       o_gpio_in,
    output logic             o_timer_two_channel_four,
    output logic             o_timer_two_channel_two,
    output logic             o_timer_one_channel_three,
    output logic             o_ctrl_two_spi_clock,
    output logic             o_ctrl_two_slave_select_n,
    output logic             o_ctrl_two_twi_clock,
    output logic             o_ctrl_one_twi_data,
    // Analog and boot
    output logic             o_analog_input_four,
    output logic             o_analog_input_five,
    output logic             o_factory_info_monitor
);
    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    // The filter compares stages two and three; other depths differ
    if (SYNC_STAGES != SYNC_DEPTH) begin : g_bad_depth
        $error("SYNC_STAGES must be 3");
    end

    // Pick nibble idx out of a 16-bit config word
    function automatic logic [3:0] nib(input logic [15:0] w,
                                       input int          idx);
        nib = w[idx*4 +: 4];
    endfunction : nib

    // ------------------------------------------------------------
    // Config decode
    // ------------------------------------------------------------
    wire logic [3:0] cfg_a2 = nib(i_port_a_low_config, NIB_A2);
    wire logic [3:0] cfg_a3 = nib(i_port_a_low_config, NIB_A3);
    wire logic [3:0] cfg_a4 = nib(i_port_a_high_config, NIB_A4);
    wire logic [3:0] cfg_a5 = nib(i_port_a_high_config, NIB_A5);
    wire logic [3:0] cfg_a6 = nib(i_port_a_high_config, NIB_A6);
    wire logic [3:0] cfg_b1 = nib(i_port_b_low_config, NIB_B1);
    wire logic [3:0] cfg_all [NPINS] =
        '{cfg_a2, cfg_a3, cfg_a4, cfg_a5, cfg_a6, cfg_b1};

    // Remap and enable shorthands
    wire logic rm1  = i_timer_two_remap_bits[REMAP_CH1];
    wire logic rm2  = i_timer_two_remap_bits[REMAP_CH2];
    wire logic rm4  = i_timer_two_remap_bits[REMAP_CH4];
    wire logic t2e1 = i_timer_two_output_enables[CH1];
    wire logic t2e2 = i_timer_two_output_enables[CH2];
    wire logic t2e4 = i_timer_two_output_enables[CH4];
    wire logic t1e3 = i_timer_one_output_enables[CH3];

    // Serial controller mode decode
    wire logic sc2_spi = (i_ctrl_two_mode_select == MODE_SPI);
    wire logic sc2_twi = (i_ctrl_two_mode_select == MODE_TWI);
    wire logic sc2_mst = i_ctrl_two_spi_role[ROLE_MST];
    wire logic sc2_slv = sc2_spi && !sc2_mst;
    wire logic sc1_spi = (i_ctrl_one_mode_select == MODE_SPI);
    wire logic sc1_twi = (i_ctrl_one_mode_select == MODE_TWI);
    wire logic sc1_uart = (i_ctrl_one_mode_select == MODE_UART);
    wire logic sc1_mst = i_ctrl_one_spi_role[ROLE_MST];

    // ------------------------------------------------------------
    // Function selects per pin
    // ------------------------------------------------------------
    // Port A bit two
    wire logic a2_pp   = (cfg_a2 == CFG_ALT_PP);
    wire logic a2_od   = (cfg_a2 == CFG_ALT_OD);
    wire logic a2_free = !t2e4 || rm4;
    wire logic sel_a2_tim = !rm4 && t2e4 && a2_pp;
    wire logic sel_a2_scl = sc2_twi && a2_od && a2_free;
    wire logic sel_a2_sck = sc2_spi && sc2_mst && a2_pp
                            && a2_free;
    // Port A bit three
    wire logic a3_pp = (cfg_a3 == CFG_ALT_PP);
    wire logic sel_a3_trc = i_trace_enable && a3_pp
                            && (!t2e2 || rm2);
    wire logic sel_a3_tim = !rm2 && t2e2 && a3_pp;
    // Port A bit four
    wire logic a4_pp  = (cfg_a4 == CFG_ALT_PP);
    wire logic an_a4  = (cfg_a4 == CFG_ANALOG);
    wire logic sel_a4_pti = !i_trace_enable && i_packet_trace_enable
                            && a4_pp;
    wire logic sel_a4_trc = i_trace_four_wire && i_trace_enable
                            && a4_pp;
    // Port A bit five
    wire logic a5_pp  = (cfg_a5 == CFG_ALT_PP);
    wire logic an_a5  = (cfg_a5 == CFG_ANALOG);
    wire logic sel_a5_pti = !i_trace_enable && i_packet_trace_enable
                            && a5_pp;
    wire logic sel_a5_trc = i_trace_four_wire && i_trace_enable
                            && a5_pp;
    // Port A bit six
    wire logic sel_a6_tim = t1e3 && (cfg_a6 == CFG_ALT_PP);
    // Port B bit one
    wire logic b1_pp   = (cfg_b1 == CFG_ALT_PP);
    wire logic b1_od   = (cfg_b1 == CFG_ALT_OD);
    wire logic b1_free = !t2e1 || !rm1;
    wire logic sel_b1_so  = sc1_spi && !sc1_mst && b1_pp
                            && b1_free;
    wire logic sel_b1_mo  = sc1_spi && sc1_mst && b1_pp
                            && b1_free;
    wire logic sel_b1_sda = sc1_twi && b1_od && b1_free;
    wire logic sel_b1_tx  = sc1_uart && b1_pp && b1_free;
    wire logic sel_b1_tim = rm1 && t2e1 && b1_pp;

    // ------------------------------------------------------------
    // Plain GPIO drive, used when no function claims the pin
    // ------------------------------------------------------------
    pin_drive_t [5:0] gpio_drv;
    always_comb begin
        for (int k = 0; k < NPINS; k++) begin
            if (cfg_all[k] == CFG_GPIO_PP) begin
                gpio_drv[k] = '{val: i_gpio_out[k], oe_n: 1'b0};
            end else if (cfg_all[k] == CFG_GPIO_OD) begin
                // Open drain: only a low level is driven
                gpio_drv[k] = '{val: 1'b0, oe_n: i_gpio_out[k]};
            end else begin
                // Input, analog or unclaimed alternate: released
                gpio_drv[k] = '{val: 1'b0, oe_n: 1'b1};
            end
        end
    end

    // ------------------------------------------------------------
    // Per-pin drive selection
    // ------------------------------------------------------------
    // Helpers for push-pull and open-drain alternate drives
    function automatic pin_drive_t pp(input logic v);
        pp = '{val: v, oe_n: 1'b0};
    endfunction : pp
    function automatic pin_drive_t od(input logic v);
        od = '{val: 1'b0, oe_n: v};
    endfunction : od

    wire pin_drive_t drv_a2 =
        sel_a2_tim ? pp(i_timer_two_channel_four) :
        sel_a2_scl ? od(i_ctrl_two_twi_clock) :
        sel_a2_sck ? pp(i_ctrl_two_spi_clock) :
        gpio_drv[P_A2];
    wire pin_drive_t drv_a3 =
        sel_a3_trc ? pp(i_cpu_trace_clock) :
        sel_a3_tim ? pp(i_timer_two_channel_two) :
        gpio_drv[P_A3];
    // Four-wire trace wins over packet trace; the two are exclusive
    wire pin_drive_t drv_a4 =
        sel_a4_trc ? pp(i_cpu_trace_bit_two) :
        sel_a4_pti ? pp(i_packet_trace_frame) :
        gpio_drv[P_A4];
    wire pin_drive_t drv_a5 =
        sel_a5_trc ? pp(i_cpu_trace_bit_three) :
        sel_a5_pti ? pp(i_packet_trace_serial) :
        gpio_drv[P_A5];
    wire pin_drive_t drv_a6 =
        sel_a6_tim ? pp(i_timer_one_channel_three) :
        gpio_drv[P_A6];
    wire pin_drive_t drv_b1 =
        sel_b1_tim ? pp(i_timer_two_channel_one) :
        sel_b1_so  ? pp(i_ctrl_one_slave_out) :
        sel_b1_mo  ? pp(i_ctrl_one_master_out) :
        sel_b1_sda ? od(i_ctrl_one_twi_data) :
        sel_b1_tx  ? pp(i_ctrl_one_uart_tx) :
        gpio_drv[P_B1];

    wire pin_drive_t [5:0] drv_next =
        {drv_b1, drv_a6, drv_a5, drv_a4, drv_a3, drv_a2};
    logic [5:0] out_next;
    logic [5:0] oe_n_next;
    always_comb begin
        for (int k = 0; k < NPINS; k++) begin
            out_next[k] = drv_next[k].val;
            oe_n_next[k] = drv_next[k].oe_n;
        end
    end

    // Registered pad drive; released while in reset
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_pin_out  <= 6'h00;
            o_pin_oe_n <= 6'h3f;
        end else begin
            o_pin_out  <= out_next;
            o_pin_oe_n <= oe_n_next;
        end
    end

    // ------------------------------------------------------------
    // Input filter: three stages, change taken when 2 and 3 agree
    // ------------------------------------------------------------
    logic [5:0] sync1_reg;
    logic [5:0] sync2_reg;
    logic [5:0] sync3_reg;
    logic [5:0] filt_reg;
    wire logic [5:0] agree = ~(sync2_reg ^ sync3_reg);
    wire logic [5:0] filt_next =
        (sync3_reg & agree) | (filt_reg & ~agree);
    always_ff @(posedge i_core_clk) begin
        sync1_reg <= i_pin_in;
        sync2_reg <= sync1_reg;
        sync3_reg <= sync2_reg;
        if (i_sys_rst) begin
            filt_reg <= 6'h3f; // Idle high, as pull-ups would
        end else begin
            filt_reg <= filt_next;
        end
    end

    // ------------------------------------------------------------
    // Input routing to peripherals
    // ------------------------------------------------------------
    // Analog A4 and A5 feed no digital input, so they read as high
    wire logic [5:0] dig_in = filt_reg |
        {2'b00, an_a5, an_a4, 2'b00};
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_gpio_in                 <= 6'h3f;
            o_timer_two_channel_four  <= 1'b0;
            o_timer_two_channel_two   <= 1'b0;
            o_timer_one_channel_three <= 1'b0;
            o_ctrl_two_spi_clock      <= 1'b0;
            o_ctrl_two_slave_select_n <= 1'b1;
            o_ctrl_two_twi_clock      <= 1'b1;
            o_ctrl_one_twi_data       <= 1'b1;
            o_analog_input_four       <= 1'b0;
            o_analog_input_five       <= 1'b0;
        end else begin
            o_gpio_in <= dig_in;
            // Remapped channels take their input from another pin
            o_timer_two_channel_four <=
                !rm4 && dig_in[P_A2];
            o_timer_two_channel_two <=
                !rm2 && dig_in[P_A3];
            o_timer_one_channel_three <= dig_in[P_A6];
            o_ctrl_two_spi_clock <=
                sc2_slv && dig_in[P_A2];
            o_ctrl_two_slave_select_n <=
                !sc2_slv || dig_in[P_A3];
            o_ctrl_two_twi_clock <=
                !sc2_twi || dig_in[P_A2];
            o_ctrl_one_twi_data <=
                !sc1_twi || dig_in[P_B1];
            o_analog_input_four <= an_a4;
            o_analog_input_five <= an_a5;
        end
    end

    // ------------------------------------------------------------
    // Boot strap: sampled through reset and one edge after it
    // ------------------------------------------------------------
    // Frozen afterwards so later use of the pin cannot change it
    logic strap_lock_reg;
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            strap_lock_reg <= 1'b0;
        end else begin
            strap_lock_reg <= 1'b1;
        end
    end
    always_ff @(posedge i_core_clk) begin
        // Filter's next value: filt_reg itself is forced high in reset
        if (!strap_lock_reg) begin
            o_factory_info_monitor <= !filt_next[P_A5];
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_sys_rst);

    a2_timer_a: assert property (sel_a2_tim |=>
        !o_pin_oe_n[P_A2]
        && o_pin_out[P_A2] == $past(i_timer_two_channel_four))
        else $error("A2 timer drive wrong");
    a2_tim_in_a: assert property (##1 !$past(rm4) |->
        o_timer_two_channel_four == $past(dig_in[P_A2]))
        else $error("Timer four input wrong");
    a2_twi_od_a: assert property (sel_a2_scl |=>
        !o_pin_out[P_A2]
        && o_pin_oe_n[P_A2] == $past(i_ctrl_two_twi_clock))
        else $error("A2 TWI clock wrong");
    a2_sck_a: assert property (sel_a2_sck && !sel_a2_tim |=>
        o_pin_out[P_A2] == $past(i_ctrl_two_spi_clock))
        else $error("A2 SPI clock wrong");
    a3_ssel_a: assert property (!sc2_slv |=>
        o_ctrl_two_slave_select_n)
        else $error("Slave select leaks");
    a3_trace_a: assert property (sel_a3_trc |=>
        o_pin_out[P_A3] == $past(i_cpu_trace_clock))
        else $error("A3 trace clock wrong");
    a4_analog_a: assert property (an_a4 |=>
        o_pin_oe_n[P_A4] && o_analog_input_four)
        else $error("A4 analog not isolated");
    a5_pti_a: assert property (sel_a5_pti && !sel_a5_trc |=>
        o_pin_out[P_A5] == $past(i_packet_trace_serial))
        else $error("A5 packet data wrong");
    strap_hold_a: assert property (strap_lock_reg
        && $past(strap_lock_reg) |-> $stable(o_factory_info_monitor))
        else $error("Boot strap changed");
    b1_tim_a: assert property (sel_b1_tim |=>
        o_pin_out[P_B1] == $past(i_timer_two_channel_one))
        else $error("B1 timer drive wrong");
    b1_uart_a: assert property (sel_b1_tx |=>
        o_pin_out[P_B1] == $past(i_ctrl_one_uart_tx))
        else $error("B1 UART drive wrong");
    filt_glitch_a: assert property ($changed(filt_reg) |->
        ((($past(sync2_reg) ^ filt_reg) | ($past(sync3_reg) ^ filt_reg))
        & (filt_reg ^ $past(filt_reg))) == 6'h00)
        else $error("Filter took a glitch");

    c_a2_twi_c: cover property (sel_a2_scl ##1 !o_pin_oe_n[P_A2]);
    c_b1_spi_c: cover property (sel_b1_so ##1 sel_b1_mo);
    c_a4_trace_c: cover property (sel_a4_trc);
    c_boot_c: cover property (o_factory_info_monitor);
endmodule : pin_function_mux

// ### sim/pad_model.sv
/* Pad and board model for the six multiplexed pins.
   Assumes a pull-up on every pad and an open board driver. */
`timescale 1ns/100ps
module pad_model (
    // Device side
    input  wire logic [5:0] i_dev_out,
    input  wire logic [5:0] i_dev_oe_n,
    // Board side, low enable pulls i_ext_val onto the pad
    input  wire logic [5:0] i_ext_val,
    input  wire logic [5:0] i_ext_en_n,
    // Resolved pad level
    output logic [5:0]      o_pad
);
    // ---------------------------------------------------------
    // Wired-AND with pull-up: a released pad reads high
    // ---------------------------------------------------------
    assign o_pad = (i_dev_out | i_dev_oe_n) & (i_ext_val | i_ext_en_n);
endmodule : pad_model

// ### sim/tb_top.sv
/* Self-checking bench for the pin function multiplexer.
   Assumes outputs settle one edge after config, five after pads. */
`timescale 1ns/100ps
module tb_top;
    import pin_mux_pkg::*;
    // Clock, reset, pads
    logic i_core_clk = 1'b0, i_sys_rst = 1'b1;
    logic [5:0] i_pin_in, o_pin_out, o_pin_oe_n, o_gpio_in, i_gpio_out;
    logic [5:0] ext_val, ext_en_n;
    // Configuration levels
    logic [15:0] i_port_a_low_config, i_port_a_high_config;
    logic [15:0] i_port_b_low_config;
    logic [7:0]  i_timer_two_remap_bits, i_ctrl_two_spi_role;
    logic [7:0]  i_ctrl_one_spi_role;
    logic [3:0]  i_timer_two_output_enables, i_timer_one_output_enables;
    sc_mode_t    i_ctrl_two_mode_select, i_ctrl_one_mode_select;
    logic i_trace_enable, i_trace_four_wire, i_packet_trace_enable;
    // Peripheral levels, one bit each in per
    logic [14:0] per;
    logic i_timer_two_channel_four, i_timer_two_channel_two;
    logic i_timer_two_channel_one, i_timer_one_channel_three;
    logic i_ctrl_two_twi_clock, i_ctrl_two_spi_clock, i_cpu_trace_clock;
    logic i_cpu_trace_bit_two, i_cpu_trace_bit_three;
    logic i_packet_trace_frame, i_packet_trace_serial;
    logic i_ctrl_one_slave_out, i_ctrl_one_master_out;
    logic i_ctrl_one_twi_data, i_ctrl_one_uart_tx;
    // Routed inputs and status
    logic o_timer_two_channel_four, o_timer_two_channel_two;
    logic o_timer_one_channel_three, o_ctrl_two_spi_clock;
    logic o_ctrl_two_slave_select_n, o_ctrl_two_twi_clock;
    logic o_ctrl_one_twi_data, o_analog_input_four;
    logic o_analog_input_five, o_factory_info_monitor;
    int n_errors = 0, compares = 0, cyc = 0;
    assign {i_ctrl_one_uart_tx, i_ctrl_one_twi_data, i_ctrl_one_master_out,
            i_ctrl_one_slave_out, i_packet_trace_serial,
            i_packet_trace_frame, i_cpu_trace_bit_three,
            i_cpu_trace_bit_two, i_cpu_trace_clock, i_ctrl_two_spi_clock,
            i_ctrl_two_twi_clock, i_timer_one_channel_three,
            i_timer_two_channel_one, i_timer_two_channel_two,
            i_timer_two_channel_four} = per;
    pin_function_mux dut_u (.*);
    pad_model pad_u (.i_dev_out(o_pin_out), .i_dev_oe_n(o_pin_oe_n),
                     .i_ext_val(ext_val), .i_ext_en_n(ext_en_n),
                     .o_pad(i_pin_in));
    // ---------------------------------------------------------
    // Clock and hang guard
    // ---------------------------------------------------------
    always #2 i_core_clk = ~i_core_clk;
    always @(posedge i_core_clk) begin
        cyc++;
        // Whole run needs about 40 cycles
        if (cyc == 3000) begin
            n_errors++;
            wrap_up();
        end
    end
    // ---------------------------------------------------------
    // Shared tasks
    // ---------------------------------------------------------
    task automatic stp;
        @(posedge i_core_clk);
        #1;
    endtask : stp
    task automatic chk(string n, logic [5:0] s, logic [5:0] e);
        compares++;
        if (s !== e) begin
            n_errors++;
            $display("[ERR] %s exp %h got %h", n, e, s);
        end
    endtask : chk
    // Nibbles per pin; 8 leaves a pin as released input
    task automatic nib(logic [3:0] a2, a3, a4, a5, a6, b1);
        i_port_a_low_config  = {a3, a2, 8'h00};
        i_port_a_high_config = {4'h0, a6, a5, a4};
        i_port_b_low_config  = {8'h00, b1, 4'h0};
    endtask : nib
    task automatic go(logic [14:0] p);
        per = p;
        stp();
    endtask : go
    // Pad k must show {oe_n, out}
    task automatic pc(int k, logic [1:0] e);
        chk("pad", {4'h0, o_pin_oe_n[k], o_pin_out[k]}, {4'h0, e});
    endtask : pc
    // ---------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------
    task automatic t_gpio;
        nib(1, 1, 1, 1, 1, 1);
        i_gpio_out = 6'h2a;
        go(15'h0000);
        chk("pp", {o_pin_oe_n, o_pin_out} == {6'h00, 6'h2a}, 6'h01);
        nib(5, 5, 5, 5, 5, 5);
        go(15'h0000);
        chk("od", o_pin_oe_n, 6'h2a);
        $display("t_gpio done");
    endtask : t_gpio
    task automatic t_a2a3;
        nib(9, 8, 8, 8, 8, 8);
        i_timer_two_output_enables = 4'h8;
        go(15'h0001);
        pc(0, 2'b01);
        i_timer_two_remap_bits = 8'h80;
        i_ctrl_two_mode_select = MODE_TWI;
        nib(4'hd, 8, 8, 8, 8, 8);
        go(~15'h0010);
        pc(0, 2'b00);
        i_timer_two_remap_bits = 8'h00;
        i_timer_two_output_enables = 4'h0;
        i_ctrl_two_mode_select = MODE_SPI;
        i_ctrl_two_spi_role = 8'h10;
        nib(9, 9, 8, 8, 8, 8);
        i_trace_enable = 1'b1;
        go(15'h0060);
        pc(0, 2'b01);
        pc(1, 2'b01);
        i_trace_enable = 1'b0;
        i_timer_two_output_enables = 4'h2;
        go(15'h0002);
        pc(1, 2'b01);
        $display("t_a2a3 done");
    endtask : t_a2a3
    task automatic t_a4a5;
        nib(8, 8, 0, 0, 8, 8);
        go(15'h0000);
        chk("ana", {o_analog_input_four, o_analog_input_five,
            o_pin_oe_n[3:2], o_gpio_in[3:2]}, 6'h3f);
        nib(8, 8, 9, 9, 8, 8);
        i_packet_trace_enable = 1'b1;
        go(15'h0200);
        chk("pti", {o_pin_oe_n[3:2], o_pin_out[3:2]}, 6'h01);
        go(15'h0400);
        chk("pti", {o_pin_oe_n[3:2], o_pin_out[3:2]}, 6'h02);
        i_trace_enable = 1'b1;
        i_trace_four_wire = 1'b1;
        go(15'h0300);
        chk("trc", {o_pin_oe_n[3:2], o_pin_out[3:2]}, 6'h02);
        $display("t_a4a5 done");
    endtask : t_a4a5
    task automatic t_a6b1;
        i_trace_enable = 1'b0;
        nib(8, 8, 8, 8, 9, 9);
        i_timer_one_output_enables = 4'h4;
        i_ctrl_one_mode_select = MODE_UART;
        go(15'h4008);
        pc(4, 2'b01);
        pc(5, 2'b01);
        i_ctrl_one_mode_select = MODE_SPI;
        go(15'h0800);
        pc(5, 2'b01);
        i_ctrl_one_spi_role = 8'h10;
        go(15'h1000);
        pc(5, 2'b01);
        i_ctrl_one_mode_select = MODE_TWI;
        nib(8, 8, 8, 8, 8, 4'hd);
        go(~15'h2000);
        pc(5, 2'b00);
        i_ctrl_one_mode_select = MODE_OFF;
        i_timer_two_remap_bits = 8'h10;
        i_timer_two_output_enables = 4'h1;
        nib(8, 8, 8, 8, 8, 9);
        go(15'h0004);
        pc(5, 2'b01);
        $display("t_a6b1 done");
    endtask : t_a6b1
    // Pads to peripherals through the input filter
    task automatic t_in(logic [5:0] v);
        nib(8, 8, 8, 8, 8, 8);
        i_timer_two_remap_bits = 8'h00;
        i_ctrl_two_mode_select = MODE_SPI;
        i_ctrl_two_spi_role = 8'h00;
        i_ctrl_one_mode_select = MODE_TWI;
        ext_val = v;
        repeat (6) stp();
        chk("gin", o_gpio_in, v);
        chk("rt", {o_timer_two_channel_four, o_ctrl_two_spi_clock,
            o_ctrl_two_slave_select_n, o_timer_one_channel_three},
            {v[0], v[0], v[1], v[4]});
        chk("twi", {o_timer_two_channel_two, o_ctrl_two_twi_clock,
            o_ctrl_one_twi_data}, {v[1], 1'b1, v[5]});
        chk("boot", o_factory_info_monitor, 6'h01);
        $display("t_in done");
    endtask : t_in
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : wrap_up
    // ---------------------------------------------------------
    // Main sequence; A5 held low through reset for the strap
    // ---------------------------------------------------------
    initial begin
        {ext_val, ext_en_n, i_gpio_out, per} = '0;
        nib(8, 8, 8, 8, 8, 8);
        {i_timer_two_remap_bits, i_ctrl_two_spi_role} = '0;
        {i_ctrl_one_spi_role, i_timer_two_output_enables} = '0;
        i_timer_one_output_enables = 4'h0;
        i_ctrl_two_mode_select = MODE_OFF;
        i_ctrl_one_mode_select = MODE_OFF;
        {i_trace_enable, i_trace_four_wire, i_packet_trace_enable} = '0;
        repeat (12) stp();
        i_sys_rst = 1'b0;
        ext_val = 6'h3f;
        stp();
        t_gpio();
        t_a2a3();
        t_a4a5();
        t_a6b1();
        t_in(6'h13);
        t_in(6'h28);
        wrap_up();
    end
endmodule : tb_top
